// >>> verification/mjd_code_ram.sv
module mjd_code_ram
    import mjd_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // loader
    input wire logic i_load,
    input wire logic [PC_W-1:0] i_load_addr,
    input wire logic [INSTR_W-1:0] i_load_data,
    // fetch
    input wire logic [PC_W-1:0] i_program_counter,
    output logic [INSTR_W-1:0] o_instr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [INSTR_W-1:0] mem [2**PC_W];
    always @(posedge i_ref_clk)
    begin
        if (i_load)
            mem[i_load_addr] <= i_load_data;
    end
    // unloaded words stay unknown, so a stray fetch shows up
    assign o_instr = mem[i_program_counter];
endmodule

// >>> verification/mjd_jump_decoder_monitor.sv
module mjd_jump_decoder_monitor
    import mjd_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // fetch
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [PC_W-1:0] o_program_counter,
    input wire logic o_jump_taken,
    // feedbacks
    input wire logic [NUM_HS-1:0] i_hs_vds_fbk,
    input wire logic [NUM_HS-1:0] i_hs_src_fbk,
    input wire logic [NUM_LS-1:0] i_ls_vds_fbk,
    // internal conditions
    input wire logic [NUM_FLAGS-1:0] i_flags,
    input wire logic i_terminal_count_one,
    input wire logic i_terminal_count_two,
    input wire logic i_terminal_count_three,
    input wire logic i_terminal_count_four,
    input wire logic i_start,
    input wire logic [NUM_SC-1:0] i_shortcut_vds_fbk,
    input wire logic [NUM_SC-1:0] i_shortcut_src_fbk,
    input wire logic i_alu_done,
    input wire logic i_boost_voltage_high,
    input wire logic [NUM_CUR-1:0] i_current_fbk,
    input wire logic i_own_current_fbk,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    input wire logic [DATA_W-1:0] o_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic [PC_W-1:0] jr0, jr1, next_jr0, next_jr1, rel, seq, t3, t4;
    logic [15:0] fv;
    logic [63:0] cv;
    logic go, fb_ok, is_fr, is_jf, is_jr, is_jc, cond_ok;
    // expected truth of each condition code
    always_comb
    begin
        cv[15:0] = ~i_flags;
        cv[31:16] = i_flags;
        cv[35:32] = {i_terminal_count_four, i_terminal_count_three,
            i_terminal_count_two, i_terminal_count_one};
        cv[36] = ~i_start;
        cv[37] = i_start;
        cv[40:38] = ~i_shortcut_vds_fbk;
        cv[43:41] = ~i_shortcut_src_fbk;
        cv[46:44] = i_shortcut_vds_fbk;
        cv[47] = i_alu_done;
        cv[48] = i_boost_voltage_high;
        cv[49] = ~i_boost_voltage_high;
        cv[55:50] = i_current_fbk;
        cv[61:56] = ~i_current_fbk;
        cv[62] = i_own_current_fbk;
        cv[63] = ~i_own_current_fbk;
    end
    assign cond_ok = cv[i_instr[10:5]];
    // shadow copies of the jump registers
    always_comb
    begin
        next_jr0 = jr0;
        next_jr1 = jr1;
        if (i_clk_en && i_wr_strobe && i_addr == 4'h0)
            next_jr0 = i_wr_data[PC_W-1:0];
        if (i_clk_en && i_wr_strobe && i_addr == 4'h1)
            next_jr1 = i_wr_data[PC_W-1:0];
    end
    always_ff @(posedge i_ref_clk)
    begin
        jr0 <= i_resetn ? next_jr0 : 10'h000;
        jr1 <= i_resetn ? next_jr1 : 10'h000;
    end
    always_comb
    begin
        for (int k = 0; k < 5; k++)
        begin
            fv[2*k] = i_hs_vds_fbk[k];
            fv[2*k+1] = i_hs_src_fbk[k];
        end
        fv[15:10] = i_ls_vds_fbk;
    end
    assign go = i_clk_en && i_instr_valid;
    assign rel = o_program_counter + {{5{i_instr[4]}}, i_instr[4:0]};
    assign seq = o_program_counter + 10'h001;
    assign t3 = i_instr[3] ? jr1 : jr0;
    assign t4 = i_instr[4] ? jr1 : jr0;
    assign fb_ok = fv[i_instr[9:6]] == i_instr[5];
    assign is_fr = i_instr[15:10] == 6'h05;
    assign is_jf = i_instr[15:4] == 12'h39a && i_instr[2:0] == 3'h5;
    assign is_jr = i_instr[15:5] == 11'h178;
    assign is_jc = i_instr[15:11] == 5'h07 && i_instr[3:0] == 4'h0;
    property p_jmpr;
        go && is_jr |=> o_jump_taken && o_program_counter == $past(rel);
    endproperty
    a_jmpr: assert property (p_jmpr)
        else $error("relative jump target wrong");
    property p_fbkr;
        go && is_fr |=> o_jump_taken == $past(fb_ok)
            && o_program_counter == ($past(fb_ok) ? $past(rel) : $past(seq));
    endproperty
    a_fbkr: assert property (p_fbkr)
        else $error("feedback jump wrong");
    property p_jmpf;
        go && is_jf |=> o_jump_taken && o_program_counter == $past(t3);
    endproperty
    a_jmpf: assert property (p_jmpf)
        else $error("far jump target wrong");
    property p_jocf;
        go && is_jc |=> o_jump_taken == $past(cond_ok)
            && o_program_counter == (o_jump_taken ? $past(t4) : $past(seq));
    endproperty
    a_jocf: assert property (p_jocf)
        else $error("conditional far jump target wrong");
    property p_seq;
        go && !(is_fr || is_jf || is_jr || is_jc)
            |=> !o_jump_taken && o_program_counter == $past(seq);
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequential advance wrong");
    property p_idle;
        i_clk_en && !i_instr_valid
            |=> !o_jump_taken && $stable(o_program_counter);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved without instruction");
    property p_freeze;
        !i_clk_en |=> $stable(o_program_counter) && $stable(o_jump_taken)
            && $stable(o_rd_data);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");
    property p_rd_jr;
        i_clk_en && i_rd_strobe && i_addr == 4'h1
            |=> o_rd_data == {6'h00, $past(jr1)};
    endproperty
    a_rd_jr: assert property (p_rd_jr)
        else $error("jump register readback wrong");
    property p_rd_none;
        i_clk_en && !(i_rd_strobe && i_addr <= 4'h2) |=> o_rd_data == '0;
    endproperty
    a_rd_none: assert property (p_rd_none)
        else $error("read data not zero");
endmodule

bind mjd_jump_decoder mjd_jump_decoder_monitor u_mjd_jump_decoder_monitor (
    .i_ref_clk, .i_resetn, .i_clk_en, .i_instr, .i_instr_valid,
    .o_program_counter, .o_jump_taken, .i_hs_vds_fbk, .i_hs_src_fbk,
    .i_ls_vds_fbk, .i_flags, .i_terminal_count_one, .i_terminal_count_two,
    .i_terminal_count_three, .i_terminal_count_four, .i_start,
    .i_shortcut_vds_fbk, .i_shortcut_src_fbk, .i_alu_done,
    .i_boost_voltage_high, .i_current_fbk, .i_own_current_fbk,
    .i_addr, .i_wr_data, .i_wr_strobe, .i_rd_strobe, .o_rd_data
);

// >>> verification/mjd_jump_decoder_tb.sv
module mjd_jump_decoder_tb
    import mjd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, valid, ld, wr, rd, taken, en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [PC_W-1:0] pc, epc;
    logic [PC_W-1:0] jr [2];
    logic [INSTR_W-1:0] instr, ldata;
    logic [15:0] fb;
    logic [35:0] sig;
    logic [6:0] m;
    int bad_count = 0;
    int n_tests = 0;
    mjd_jump_decoder u_mjd_jump_decoder (
        .i_ref_clk(clk), .i_resetn(resetn), .i_clk_en(en),
        .i_instr(instr), .i_instr_valid(valid),
        .o_program_counter(pc), .o_jump_taken(taken),
        .i_hs_vds_fbk({fb[8], fb[6], fb[4], fb[2], fb[0]}),
        .i_hs_src_fbk({fb[9], fb[7], fb[5], fb[3], fb[1]}),
        .i_ls_vds_fbk(fb[15:10]), .i_flags(sig[15:0]),
        .i_terminal_count_one(sig[16]), .i_terminal_count_two(sig[17]),
        .i_terminal_count_three(sig[18]), .i_terminal_count_four(sig[19]),
        .i_start(sig[20]), .i_shortcut_vds_fbk(sig[23:21]),
        .i_shortcut_src_fbk(sig[26:24]), .i_alu_done(sig[27]),
        .i_boost_voltage_high(sig[28]), .i_current_fbk(sig[34:29]),
        .i_own_current_fbk(sig[35]), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_strobe(wr), .i_rd_strobe(rd), .o_rd_data(rdata)
    );
    mjd_code_ram u_mjd_code_ram (
        .i_ref_clk(clk), .i_load(ld), .i_load_addr(epc),
        .i_load_data(ldata), .i_program_counter(pc), .o_instr(instr)
    );
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_v(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(string nm, logic e, logic g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    // load the word at the expected address, then execute it once
    task automatic step(logic [15:0] w, logic t, logic [PC_W-1:0] dst);
        @(posedge clk);
        ld <= 1;
        ldata <= w;
        @(posedge clk);
        ld <= 0;
        valid <= 1;
        @(posedge clk);
        valid <= 0;
        #1;
        epc = t ? dst : epc + 10'h001;
        chk_v("program_counter", 16'(epc), 16'(pc));
        chk_b("jump_taken", t, taken);
    endtask
    task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        chk_v("rd_data", e, rdata);
    endtask
    // {active level, raw signal index} for each condition code
    function automatic logic [6:0] cmap(int c);
        if (c < 36)
            return {c >= 16, 6'(c < 16 ? c : c - 16)};
        if (c < 38)
            return {c == 37, 6'h14};
        if (c < 44)
            return {1'b0, 6'(c - 17)};
        if (c < 47)
            return {1'b1, 6'(c - 23)};
        if (c == 47)
            return {1'b1, 6'h1b};
        if (c < 50)
            return {c == 48, 6'h1c};
        if (c < 56)
            return {1'b1, 6'(c - 21)};
        if (c < 62)
            return {1'b0, 6'(c - 27)};
        return {c == 62, 6'h23};
    endfunction
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test;
    end
    initial
    begin
        {resetn, valid, ld, wr, rd, addr, wdata, ldata} = '0;
        {fb, sig, epc} = '0;
        en = 1'b1;
        repeat (2) @(posedge clk);
        resetn <= 1;
        #1;
        chk_v("program_counter", 16'h0000, 16'(pc));
        rd_reg(REG_STATUS, 16'h0000);
        wr_reg(REG_JUMP0, 16'hf123);
        wr_reg(REG_JUMP1, 16'h02aa);
        wr_reg(4'h7, 16'hffff);
        rd_reg(REG_JUMP0, 16'h0123);
        rd_reg(REG_JUMP1, 16'h02aa);
        rd_reg(4'h7, 16'h0000);
        jr[0] = 10'h123;
        jr[1] = 10'h2aa;
        step(16'h2f0f, 1, 10'h00f);
        step(16'h2f10, 1, 10'h3ff);
        step(16'h2f1f, 1, 10'h3fe);
        step(16'hffff, 0, 10'h000);
        step(16'h39a5, 1, jr[0]);
        step(16'h39ad, 1, jr[1]);
        // frozen edges must ignore a presented jump, then it runs
        @(posedge clk);
        ld <= 1;
        ldata <= 16'h2f01;
        @(posedge clk);
        ld <= 0;
        valid <= 1;
        en <= 0;
        repeat (2) @(posedge clk);
        en <= 1;
        #1;
        chk_v("program_counter", 16'(epc), 16'(pc));
        @(posedge clk);
        valid <= 0;
        rd <= 1;
        addr <= REG_STATUS;
        @(posedge clk);
        rd <= 0;
        #1;
        epc = epc + 10'h001;
        chk_v("rd_data", {1'b1, 5'h00, epc}, rdata);
        for (int s = 0; s < 16; s++)
            for (int p = 0; p < 4; p++)
            begin
                @(posedge clk);
                fb <= p[1] ? 16'h0001 << s : ~(16'h0001 << s);
                step({6'h05, 4'(s), p[0], 5'h1d}, p[1] == p[0],
                    epc - 10'h003);
            end
        for (int c = 0; c < 64; c++)
            for (int l = 0; l < 2; l++)
            begin
                m = cmap(c);
                @(posedge clk);
                sig <= l[0] ? 36'h1 << m[5:0] : ~(36'h1 << m[5:0]);
                step({5'h07, 6'(c), c[0], 4'h0}, m[6] == l[0],
                    jr[c[0]]);
            end
        rd_reg(REG_STATUS, 16'(epc));
        @(posedge clk);
        resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        #1;
        epc = '0;
        chk_v("program_counter", 16'h0000, 16'(pc));
        rd_reg(REG_JUMP1, 16'h0000);
        finish_test;
    end
endmodule

// >>> verilog/mjd_cond_eval.sv
module mjd_cond_eval
    import mjd_pkg::*;
(
    // selection
    input wire logic [FBK_SEL_W-1:0] i_feedback_selector,
    input wire logic i_polarity,
    input wire logic [COND_W-1:0] i_cond_sel,
    // driver feedbacks
    input wire logic [NUM_HS-1:0] i_hs_vds_fbk,
    input wire logic [NUM_HS-1:0] i_hs_src_fbk,
    input wire logic [NUM_LS-1:0] i_ls_vds_fbk,
    // internal conditions
    input wire logic [NUM_FLAGS-1:0] i_flags,
    input wire logic i_terminal_count_one,
    input wire logic i_terminal_count_two,
    input wire logic i_terminal_count_three,
    input wire logic i_terminal_count_four,
    input wire logic i_start,
    input wire logic [NUM_SC-1:0] i_shortcut_vds_fbk,
    input wire logic [NUM_SC-1:0] i_shortcut_src_fbk,
    input wire logic i_alu_done,
    input wire logic i_boost_voltage_high,
    input wire logic [NUM_CUR-1:0] i_current_fbk,
    input wire logic i_own_current_fbk,
    // results
    output logic o_fbk_match,
    output logic o_cond_true
);
    logic [15:0] fbk_vec;
    logic [63:0] cond_vec;

    genvar g;
    generate
        for (g = 0; g < NUM_HS; g++)
        begin : g_hs
            assign fbk_vec[2*g] = i_hs_vds_fbk[g];
            assign fbk_vec[2*g+1] = i_hs_src_fbk[g];
        end
        for (g = 0; g < NUM_FLAGS; g++)
        begin : g_flag
            assign cond_vec[COND_FLAG_LOW+g] = ~i_flags[g];
            assign cond_vec[COND_FLAG_HIGH+g] = i_flags[g];
        end
    endgenerate

    assign fbk_vec[FBK_LS_BASE +: NUM_LS] = i_ls_vds_fbk;

    assign cond_vec[COND_TC] = i_terminal_count_one;
    assign cond_vec[COND_TC+1] = i_terminal_count_two;
    assign cond_vec[COND_TC+2] = i_terminal_count_three;
    assign cond_vec[COND_TC+3] = i_terminal_count_four;
    assign cond_vec[COND_START_LOW] = ~i_start;
    assign cond_vec[COND_START_HIGH] = i_start;
    assign cond_vec[COND_SC_VDS_LOW +: NUM_SC] = ~i_shortcut_vds_fbk;
    assign cond_vec[COND_SC_SRC_LOW +: NUM_SC] = ~i_shortcut_src_fbk;
    assign cond_vec[COND_SC_VDS_HIGH +: NUM_SC] = i_shortcut_vds_fbk;
    assign cond_vec[COND_ALU_DONE] = i_alu_done;
    assign cond_vec[COND_BOOST_HIGH] = i_boost_voltage_high;
    assign cond_vec[COND_BOOST_LOW] = ~i_boost_voltage_high;
    assign cond_vec[COND_CUR_HIGH +: NUM_CUR] = i_current_fbk;
    assign cond_vec[COND_CUR_LOW +: NUM_CUR] = ~i_current_fbk;
    assign cond_vec[COND_OWN_HIGH] = i_own_current_fbk;
    assign cond_vec[COND_OWN_LOW] = ~i_own_current_fbk;

    // pol 0 matches a low level, pol 1 a high level
    assign o_fbk_match = (fbk_vec[i_feedback_selector] == i_polarity);
    assign o_cond_true = cond_vec[i_cond_sel];
endmodule

// >>> verilog/mjd_jump_decoder.sv
module mjd_jump_decoder
    import mjd_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // instruction fetch
    input wire logic [INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    output logic [PC_W-1:0] o_program_counter,
    output logic o_jump_taken,
    // driver feedbacks
    input wire logic [NUM_HS-1:0] i_hs_vds_fbk,
    input wire logic [NUM_HS-1:0] i_hs_src_fbk,
    input wire logic [NUM_LS-1:0] i_ls_vds_fbk,
    // internal conditions
    input wire logic [NUM_FLAGS-1:0] i_flags,
    input wire logic i_terminal_count_one,
    input wire logic i_terminal_count_two,
    input wire logic i_terminal_count_three,
    input wire logic i_terminal_count_four,
    input wire logic i_start,
    input wire logic [NUM_SC-1:0] i_shortcut_vds_fbk,
    input wire logic [NUM_SC-1:0] i_shortcut_src_fbk,
    input wire logic i_alu_done,
    input wire logic i_boost_voltage_high,
    input wire logic [NUM_CUR-1:0] i_current_fbk,
    input wire logic i_own_current_fbk,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    output logic [DATA_W-1:0] o_rd_data
);
    logic [PC_W-1:0] program_counter;
    logic [PC_W-1:0] next_program_counter;
    logic jump_taken;
    logic next_jump_taken;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] next_rd_data;

    logic is_fbkr;
    logic is_jmpf;
    logic is_jmpr;
    logic is_jocf;
    logic fbk_match;
    logic cond_true;
    logic jump_register_select;
    logic [PC_W-1:0] far_target;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] seq_target;
    logic [DISP_W-1:0] disp;
    logic jreg_wr_en;
    logic [PC_W-1:0] bus_jreg;

    assign is_fbkr = (i_instr[15:10] == OP_FBKR);
    assign is_jmpf = (i_instr[15:4] == OP_JMPF_HI)
        && (i_instr[2:0] == OP_JMPF_LO);
    assign is_jmpr = (i_instr[15:5] == OP_JMPR);
    assign is_jocf = (i_instr[15:11] == OP_JOCF_HI)
        && (i_instr[3:0] == OP_JOCF_LO);

    // each far form keeps its register select in a different bit
    assign jump_register_select = is_jmpf ? i_instr[JMPF_REG_BIT]
        : i_instr[JOCF_REG_BIT];

    assign disp = i_instr[DISP_LSB +: DISP_W];
    // relative to the address of the instruction now presented
    assign rel_target = program_counter
        + {{(PC_W-DISP_W){disp[DISP_W-1]}}, disp};
    assign seq_target = program_counter + PC_W'(1);

    mjd_cond_eval u_cond
    (
        .i_feedback_selector(i_instr[FBK_SEL_LSB +: FBK_SEL_W]),
        .i_polarity(i_instr[POL_BIT]),
        .i_cond_sel(i_instr[COND_LSB +: COND_W]),
        .i_hs_vds_fbk(i_hs_vds_fbk),
        .i_hs_src_fbk(i_hs_src_fbk),
        .i_ls_vds_fbk(i_ls_vds_fbk),
        .i_flags(i_flags),
        .i_terminal_count_one(i_terminal_count_one),
        .i_terminal_count_two(i_terminal_count_two),
        .i_terminal_count_three(i_terminal_count_three),
        .i_terminal_count_four(i_terminal_count_four),
        .i_start(i_start),
        .i_shortcut_vds_fbk(i_shortcut_vds_fbk),
        .i_shortcut_src_fbk(i_shortcut_src_fbk),
        .i_alu_done(i_alu_done),
        .i_boost_voltage_high(i_boost_voltage_high),
        .i_current_fbk(i_current_fbk),
        .i_own_current_fbk(i_own_current_fbk),
        .o_fbk_match(fbk_match),
        .o_cond_true(cond_true)
    );

    assign jreg_wr_en = i_wr_strobe
        && ((i_addr == REG_JUMP0) || (i_addr == REG_JUMP1));

    mjd_jump_regs u_jregs
    (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_wr_en(jreg_wr_en),
        .i_wr_idx(i_addr[0]),
        .i_wr_data(i_wr_data[PC_W-1:0]),
        .i_target_sel(jump_register_select),
        .o_target(far_target),
        .i_bus_sel(i_addr[0]),
        .o_bus_data(bus_jreg)
    );

    always_comb
    begin
        next_program_counter = program_counter;
        next_jump_taken = 1'b0;
        if (i_instr_valid)
        begin
            next_program_counter = seq_target;
            if (is_fbkr && fbk_match)
            begin
                next_program_counter = rel_target;
                next_jump_taken = 1'b1;
            end
            else if (is_jmpf)
            begin
                next_program_counter = far_target;
                next_jump_taken = 1'b1;
            end
            else if (is_jmpr)
            begin
                next_program_counter = rel_target;
                next_jump_taken = 1'b1;
            end
            else if (is_jocf && cond_true)
            begin
                next_program_counter = far_target;
                next_jump_taken = 1'b1;
            end
        end
    end

    always_comb
    begin
        next_rd_data = '0;
        if (i_rd_strobe)
        begin
            unique case (i_addr)
                REG_JUMP0, REG_JUMP1:
                begin
                    next_rd_data[PC_W-1:0] = bus_jreg;
                end
                REG_STATUS:
                begin
                    next_rd_data[PC_W-1:0] = program_counter;
                    next_rd_data[STATUS_TAKEN_BIT] = jump_taken;
                end
                default:
                begin
                    next_rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            program_counter <= RESET_PC;
            jump_taken <= 1'b0;
            rd_data <= '0;
        end
        else if (i_clk_en)
        begin
            program_counter <= next_program_counter;
            jump_taken <= next_jump_taken;
            rd_data <= next_rd_data;
        end
    end

    assign o_program_counter = program_counter;
    assign o_jump_taken = jump_taken;
    assign o_rd_data = rd_data;
endmodule

// >>> verilog/mjd_jump_regs.sv
module mjd_jump_regs
    import mjd_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    // write port
    input wire logic i_wr_en,
    input wire logic i_wr_idx,
    input wire logic [PC_W-1:0] i_wr_data,
    // read ports
    input wire logic i_target_sel,
    output logic [PC_W-1:0] o_target,
    input wire logic i_bus_sel,
    output logic [PC_W-1:0] o_bus_data
);
    logic [PC_W-1:0] jump_register_set [NUM_JUMP_REGS];
    logic [PC_W-1:0] next_jump_register_set [NUM_JUMP_REGS];

    always_comb
    begin
        for (int k = 0; k < NUM_JUMP_REGS; k++)
        begin
            next_jump_register_set[k] = jump_register_set[k];
        end
        if (i_wr_en)
        begin
            next_jump_register_set[i_wr_idx] = i_wr_data;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            for (int k = 0; k < NUM_JUMP_REGS; k++)
            begin
                jump_register_set[k] <= RESET_JUMP_REG;
            end
        end
        else if (i_clk_en)
        begin
            jump_register_set <= next_jump_register_set;
        end
    end

    // combinational target so a far jump resolves in the same cycle
    assign o_target = jump_register_set[i_target_sel];
    assign o_bus_data = jump_register_set[i_bus_sel];
endmodule

// >>> verilog/mjd_pkg.sv
// Overview of operation
// - taken relative jump loads current address plus sign-extended offset
// - offset field is five-bit two's complement, range -16 to +15
// - feedback relative jump taken only when feedback matches polarity
// - selector 0..9 picks high-side vds/source pairs, 10..15 low-side vds
// - polarity 0 means active low, polarity 1 means active high
// - feedback jump: bits 15:10 000101, sel 9:6, pol 5, offset 4:0
// - unconditional far jump always loads selected jump register
// - far jump: bits 15:4 001110011010, 2:0 101, register select 3
// - unconditional relative jump: bits 15:5 00101111000, offset 4:0
// - conditional far jump loads jump register target only if true
// - codes 0..15 test flags low, codes 16..31 test flags high
// - codes 32..35 terminal counts, 36 start low, 37 start high
// - shortcut vds low, shortcut source low, shortcut vds high groups
// - code 47 alu done, 48 boost high, 49 boost low
// - current feedbacks high then low, then own current high and low
// - conditional far jump: bits 15:11 00111, 3:0 0000, cond 10:5, reg 4
package mjd_pkg;
    localparam int INSTR_W = 16;
    localparam int PC_W = 10;
    localparam int DISP_W = 5;
    localparam int FBK_SEL_W = 4;
    localparam int COND_W = 6;
    localparam int NUM_FLAGS = 16;
    localparam int NUM_HS = 5;
    localparam int NUM_LS = 6;
    localparam int NUM_SC = 3;
    localparam int NUM_CUR = 6;
    localparam int NUM_JUMP_REGS = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // instruction fields
    localparam int DISP_LSB = 0;
    localparam int FBK_SEL_LSB = 6;
    localparam int POL_BIT = 5;
    localparam int JMPF_REG_BIT = 3;
    localparam int JOCF_REG_BIT = 4;
    localparam int COND_LSB = 5;
    localparam logic [5:0] OP_FBKR = 6'h05;
    localparam logic [11:0] OP_JMPF_HI = 12'h39a;
    localparam logic [2:0] OP_JMPF_LO = 3'h5;
    localparam logic [10:0] OP_JMPR = 11'h178;
    localparam logic [4:0] OP_JOCF_HI = 5'h07;
    localparam logic [3:0] OP_JOCF_LO = 4'h0;

    // feedback selector layout
    localparam int FBK_LS_BASE = 10;

    // condition code bases
    localparam int COND_FLAG_LOW = 0;
    localparam int COND_FLAG_HIGH = 16;
    localparam int COND_TC = 32;
    localparam int COND_START_LOW = 36;
    localparam int COND_START_HIGH = 37;
    localparam int COND_SC_VDS_LOW = 38;
    localparam int COND_SC_SRC_LOW = 41;
    localparam int COND_SC_VDS_HIGH = 44;
    localparam int COND_ALU_DONE = 47;
    localparam int COND_BOOST_HIGH = 48;
    localparam int COND_BOOST_LOW = 49;
    localparam int COND_CUR_HIGH = 50;
    localparam int COND_CUR_LOW = 56;
    localparam int COND_OWN_HIGH = 62;
    localparam int COND_OWN_LOW = 63;

    // register port map
    localparam logic [ADDR_W-1:0] REG_JUMP0 = 4'h0;
    localparam logic [ADDR_W-1:0] REG_JUMP1 = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
    localparam int STATUS_TAKEN_BIT = 15;

    // reset values
    localparam logic [PC_W-1:0] RESET_PC = 10'h000;
    localparam logic [PC_W-1:0] RESET_JUMP_REG = 10'h000;
endpackage
